//--- mode_ctrl.v
`timescale 1ns/100ps
`include "mode_ctrl_consts.vh"
module mode_ctrl #(
  parameter SLEEP_HOLD = `SLEEP_HOLD_CYC,
  parameter WAKE_FILT = `WAKE_FILT_CYC
) (
  input wire I_CLK,
  input wire I_RST_N,
  input wire I_MODE_SEL_HIGH,
  input wire I_STANDBY_LOW_PIN,
  input wire I_BUS_DOMINANT,
  input wire I_VS_OK,
  input wire I_VIO_OK,
  input wire I_VCC_OK,
  output reg [1:0] O_MODE,
  output reg O_RXD,
  output reg O_FAULT_FLAG_OUT_N,
  output reg O_WAKE_PENDING
);
  // state codes, one-hot
  localparam ST_STANDBY = 4'b0001;
  localparam ST_NORMAL = 4'b0010;
  localparam ST_GOSLEEP = 4'b0100;
  localparam ST_SLEEP = 4'b1000;

  // =====================================================================
  // input synchronisers
  // =====================================================================
  reg [4:0] meta_reg;
  reg [4:0] sync_reg;
  wire en_s = sync_reg[0];
  wire stb_n_s = sync_reg[1];
  wire vs_s = sync_reg[2];
  wire vio_s = sync_reg[3];
  wire vcc_s = sync_reg[4];

  // pins and supply monitors come from outside the clock domain
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      meta_reg <= 5'h00;
      sync_reg <= 5'h00;
    end else begin
      meta_reg <= {I_VCC_OK, I_VIO_OK, I_VS_OK, I_STANDBY_LOW_PIN,
                   I_MODE_SEL_HIGH};
      sync_reg <= meta_reg;
    end
  end

  // =====================================================================
  // bus wake detection
  // =====================================================================
  wire bus_s;
  wire wake_hit;
  reg bus_last_reg;
  reg edge_seen_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;

  // filter counts only after a fresh edge has armed it
  sync_filter #(
    .COUNT(WAKE_FILT),
    .CW(8)
  ) u_wake (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_async(I_BUS_DOMINANT),
    .i_arm(edge_seen_reg),
    .o_sync(bus_s),
    .o_hit(wake_hit)
  );

  // a bus already dominant at sleep entry never arms the filter
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      bus_last_reg <= 1'b1;
      edge_seen_reg <= 1'b0;
    end else begin
      bus_last_reg <= bus_s;
      if (state_reg != ST_SLEEP || !bus_s)
        edge_seen_reg <= 1'b0;
      else if (!bus_last_reg && bus_s)
        edge_seen_reg <= 1'b1;
    end
  end

  // =====================================================================
  // supply state and wake reporting qualifier
  // =====================================================================
  wire all_ok = vs_s && vio_s && vcc_s;
  reg vs_fault_reg;

  // vs loss or power-up blocks wake reporting until a pin command
  always @(posedge I_CLK) begin
    if (!I_RST_N)
      vs_fault_reg <= 1'b1;
    else if (!vs_s)
      vs_fault_reg <= 1'b1;
    else if (all_ok && en_s)
      vs_fault_reg <= 1'b0;
  end

  // =====================================================================
  // sleep hold counter
  // =====================================================================
  reg [15:0] hold_reg;
  wire sleep_cmd = en_s && !stb_n_s;
  wire hold_done = (hold_reg == SLEEP_HOLD[15:0] - 16'h0001);

  // restarts whenever the go-to-sleep state is not held
  always @(posedge I_CLK) begin
    if (!I_RST_N || state_reg != ST_GOSLEEP)
      hold_reg <= 16'h0000;
    else if (!hold_done)
      hold_reg <= hold_reg + 16'h0001;
  end

  // =====================================================================
  // command lock after a wake
  // =====================================================================
  reg [1:0] pins_last_reg;
  reg cmd_lock_reg;
  wire pins_moved = ({en_s, stb_n_s} != pins_last_reg);
  wire cmd_ok = all_ok && !cmd_lock_reg;

  // a wake lands in standby with the sleep pins often still set; pin
  // commands wait until the host moves a pin, so a stale sleep request
  // is not applied a second time and the wake report stands
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      pins_last_reg <= 2'h0;
      cmd_lock_reg <= 1'b0;
    end else begin
      pins_last_reg <= {en_s, stb_n_s};
      if (state_reg == ST_SLEEP && wake_hit)
        cmd_lock_reg <= 1'b1;
      else if (pins_moved)
        cmd_lock_reg <= 1'b0;
    end
  end

  // =====================================================================
  // mode state machine; bus level reaches it only through wake_hit
  // =====================================================================
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_STANDBY: begin
        if (cmd_ok && sleep_cmd)
          state_next = ST_GOSLEEP;
        else if (cmd_ok && en_s && stb_n_s)
          state_next = ST_NORMAL;
      end
      ST_NORMAL: begin
        if (!all_ok)
          state_next = ST_STANDBY;
        else if (sleep_cmd)
          state_next = ST_GOSLEEP;
        else if (!stb_n_s)
          state_next = ST_STANDBY;
      end
      ST_GOSLEEP: begin
        if (!all_ok)
          state_next = ST_STANDBY;
        else if (!sleep_cmd)
          state_next = stb_n_s ? ST_NORMAL : ST_STANDBY;
        else if (hold_done)
          state_next = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!vs_s)
          state_next = ST_STANDBY;
        else if (wake_hit)
          state_next = ST_STANDBY;
        else if (all_ok && en_s && stb_n_s)
          state_next = ST_NORMAL;
      end
      default: state_next = ST_STANDBY;
    endcase
  end

  always @(posedge I_CLK) begin
    if (!I_RST_N)
      state_reg <= ST_STANDBY;
    else
      state_reg <= state_next;
  end

  // =====================================================================
  // registered outputs
  // =====================================================================
  // wake report is latched and held until the host selects normal mode or vs is lost
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_MODE <= `MODE_STANDBY;
      O_WAKE_PENDING <= 1'b0;
      O_RXD <= 1'b1;
      O_FAULT_FLAG_OUT_N <= 1'b1;
    end else begin
      case (state_next)
        ST_NORMAL: O_MODE <= `MODE_NORMAL;
        ST_SLEEP: O_MODE <= `MODE_SLEEP;
        default: O_MODE <= `MODE_STANDBY;
      endcase
      if (state_reg == ST_SLEEP && wake_hit && !vs_fault_reg)
        O_WAKE_PENDING <= 1'b1;
      else if (state_next == ST_NORMAL || !vs_s)
        O_WAKE_PENDING <= 1'b0;
      if (state_next == ST_NORMAL) begin
        O_RXD <= !bus_s;
        O_FAULT_FLAG_OUT_N <= 1'b1;
      end else begin
        O_RXD <= !(O_WAKE_PENDING && state_reg == ST_STANDBY);
        O_FAULT_FLAG_OUT_N <= !(O_WAKE_PENDING &&
                                state_reg == ST_STANDBY);
      end
    end
  end
endmodule // mode_ctrl

//--- mode_ctrl_consts.vh
`ifndef MODE_CTRL_CONSTS_VH
`define MODE_CTRL_CONSTS_VH

// =====================================================================
// timing figures in nanoseconds, and the clock period
// =====================================================================
`define CLK_PERIOD_NS 50
`define SLEEP_HOLD_MIN_NS 8000
`define SLEEP_HOLD_MAX_NS 50000
`define WAKE_FILT_MIN_NS 750
`define WAKE_FILT_MAX_NS 5000

// sleep hold: least time, round up (160 cycles)
`define SLEEP_HOLD_CYC \
  ((`SLEEP_HOLD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// wake filter: least time, round up (15 cycles)
`define WAKE_FILT_CYC \
  ((`WAKE_FILT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// =====================================================================
// mode encodings on the mode output
// =====================================================================
`define MODE_STANDBY 2'h0
`define MODE_NORMAL 2'h1
`define MODE_RX_ONLY 2'h2
`define MODE_SLEEP 2'h3

`endif

//--- sync_filter.v
`timescale 1ns/100ps
// =====================================================================
// two-flop synchroniser followed by a qualification counter
// =====================================================================
module sync_filter #(
  parameter COUNT = 15,
  parameter CW = 8
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_async,
  input wire i_arm,
  output reg o_sync,
  output reg o_hit
);
  reg meta_reg;
  reg [CW-1:0] cnt_reg;

  // first flop is read only by the second flop
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_reg <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

  // counts synchronised high cycles while armed; hit is sticky until
  // disarmed or the synchronised input falls, so the caller sees a stable level
  always @(posedge i_clk) begin
    if (!i_rst_n || !i_arm || !o_sync) begin
      cnt_reg <= {CW{1'b0}};
      o_hit <= 1'b0;
    end else if (cnt_reg == COUNT[CW-1:0] - 1'b1) begin
      o_hit <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule // sync_filter

//--- mode_ctrl_assertions.sv
`timescale 1ns/100ps
// ====================================================================
// port checker for the mode controller
// ====================================================================
module mode_ctrl_checker #(
  parameter SLEEP_HOLD = 4,
  parameter WAKE_FILT = 3
) (
  input wire I_CLK,
  input wire I_RST_N,
  input wire I_MODE_SEL_HIGH,
  input wire I_STANDBY_LOW_PIN,
  input wire I_BUS_DOMINANT,
  input wire I_VS_OK,
  input wire I_VIO_OK,
  input wire I_VCC_OK,
  input wire [1:0] O_MODE,
  input wire O_RXD,
  input wire O_FAULT_FLAG_OUT_N,
  input wire O_WAKE_PENDING
);
  wire slp = I_MODE_SEL_HIGH && !I_STANDBY_LOW_PIN;
  wire ok = I_VS_OK && I_VIO_OK && I_VCC_OK;
  wire [5:0] pins = {I_MODE_SEL_HIGH, I_STANDBY_LOW_PIN, I_BUS_DOMINANT,
    I_VS_OK, I_VIO_OK, I_VCC_OK};
  reg seen_reg;
  // raw pins arm early, so this is never stricter than the device
  always @(posedge I_CLK) begin
    if (!I_RST_N || !I_VS_OK) seen_reg <= 1'b0;
    else if (I_MODE_SEL_HIGH && ok) seen_reg <= 1'b1;
  end
  reg [1:0] prev_mode_reg;
  reg [2:0] dom_hist_reg;
  reg stuck_reg;
  reg [15:0] slp_cnt_reg;
  // stuck: bus dominant since before sleep entry, so no fresh edge;
  // slp count: cycles since the sleep pins rose, blocked by a wake exit
  // or a supply loss until the pins fall again
  always @(posedge I_CLK) begin
    prev_mode_reg <= O_MODE;
    dom_hist_reg <= {dom_hist_reg[1:0], I_BUS_DOMINANT};
    if (!I_RST_N || !I_BUS_DOMINANT || O_MODE != 2'h3)
      stuck_reg <= 1'b0;
    else if (prev_mode_reg != 2'h3 && &dom_hist_reg)
      stuck_reg <= 1'b1;
    if (!I_RST_N || !slp)
      slp_cnt_reg <= 16'h0000;
    else if (!ok || (prev_mode_reg == 2'h3 && O_MODE != 2'h3))
      slp_cnt_reg <= 16'hffff;
    else if (slp_cnt_reg != 16'hffff)
      slp_cnt_reg <= slp_cnt_reg + 16'h0001;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  property p_go_sleep;
    slp_cnt_reg == SLEEP_HOLD + 3 |-> ##[0:1] O_MODE == 2'h3;
  endproperty
  a_go_sleep: assert property (p_go_sleep) else $error("no sleep");
  property p_no_supply;
    (!I_VCC_OK)[*6] ##0 O_MODE == 2'h0 |=> O_MODE == 2'h0;
  endproperty
  a_no_supply: assert property (p_no_supply) else $error("moved");
  property p_hold;
    O_MODE == 2'h3 && $past(O_MODE) != 2'h3
      |-> $past(slp, 3) && $past(slp, SLEEP_HOLD + 2);
  endproperty
  a_hold: assert property (p_hold) else $error("early sleep");
  property p_dom_stay;
    stuck_reg && O_MODE == 2'h3 && $past(slp, 2) && $past(I_VS_OK, 2)
      |=> O_MODE == 2'h3;
  endproperty
  a_dom_stay: assert property (p_dom_stay) else $error("left");
  property p_filter;
    $rose(O_WAKE_PENDING)
      |-> $past(I_BUS_DOMINANT) && $past(I_BUS_DOMINANT, WAKE_FILT);
  endproperty
  a_filter: assert property (p_filter) else $error("short wake");
  property p_quiet;
    (!seen_reg)[*5] ##0 O_MODE != 2'h1 |-> O_FAULT_FLAG_OUT_N && O_RXD;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reported");
  property p_abort;
    $fell(slp) && !$past(slp, 3) && O_MODE != 2'h3 |=> (O_MODE != 2'h3)[*6];
  endproperty
  a_abort: assert property (p_abort) else $error("slept");
  property p_stable;
    (!slp && !I_BUS_DOMINANT && $stable(pins))[*8] |=> $stable(O_MODE);
  endproperty
  a_stable: assert property (p_stable) else $error("drift");
  c_sleep: cover property (O_MODE == 2'h3);
  c_wake: cover property ($rose(O_WAKE_PENDING));
  c_abort: cover property ($fell(slp) && O_MODE == 2'h1);
  c_dom_sleep: cover property (stuck_reg && O_MODE == 2'h3);
endmodule // mode_ctrl_checker

bind mode_ctrl mode_ctrl_checker #(
  .SLEEP_HOLD(SLEEP_HOLD), .WAKE_FILT(WAKE_FILT)) u_mode_ctrl_checker (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_MODE_SEL_HIGH(I_MODE_SEL_HIGH),
  .I_STANDBY_LOW_PIN(I_STANDBY_LOW_PIN), .I_BUS_DOMINANT(I_BUS_DOMINANT),
  .I_VS_OK(I_VS_OK), .I_VIO_OK(I_VIO_OK), .I_VCC_OK(I_VCC_OK),
  .O_MODE(O_MODE), .O_RXD(O_RXD), .O_FAULT_FLAG_OUT_N(O_FAULT_FLAG_OUT_N),
  .O_WAKE_PENDING(O_WAKE_PENDING));

//--- host_bus_model.sv
`timescale 1ns/100ps
// ====================================================================
// host pins, bus level and supplies as one vector
// ====================================================================
module host_bus_model (
  input wire logic i_clk,
  output logic [5:0] o_pins
);
  // rest in standby with the bus recessive and all supplies up
  initial o_pins = 6'h07;
  // changes land 5 ns after the edge, then hold for n edges
  task automatic drive(input logic [5:0] v, input int n);
    @(posedge i_clk);
    #5;
    o_pins = v;
    repeat (n) @(posedge i_clk);
    #1;
  endtask
endmodule // host_bus_model

//--- mode_ctrl_tb.sv
`timescale 1ns/100ps
// ====================================================================
// bench for the mode controller
// ====================================================================
module mode_ctrl_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  wire [5:0] p;
  wire [1:0] mode;
  wire rxd, flt_n, wpend;
  int fails = 0;
  int num_checks = 0;
  host_bus_model u_host_bus_model (.i_clk(clk), .o_pins(p));
  // short counts keep the run brief
  mode_ctrl #(.SLEEP_HOLD(4), .WAKE_FILT(3)) u_mode_ctrl (
    .I_CLK(clk), .I_RST_N(rst_n), .I_MODE_SEL_HIGH(p[5]),
    .I_STANDBY_LOW_PIN(p[4]), .I_BUS_DOMINANT(p[3]), .I_VS_OK(p[2]),
    .I_VIO_OK(p[1]), .I_VCC_OK(p[0]), .O_MODE(mode), .O_RXD(rxd),
    .O_FAULT_FLAG_OUT_N(flt_n), .O_WAKE_PENDING(wpend));
  // 20 MHz clock
  initial forever #25 clk = ~clk;
  task automatic check(input logic [1:0] s, input logic [1:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // bounded wait; running out counts as a mismatch
  task automatic wait_mode(input logic [1:0] m);
    int i;
    i = 0;
    while (mode !== m && i < 40) begin
      @(posedge clk);
      #1;
      i++;
    end
    check(mode, m);
    if (mode !== m) report_and_stop();
  endtask
  task t_supply;
    check({rxd, flt_n}, 2'h3);
    check({1'b0, wpend}, 2'h0);
    u_host_bus_model.drive(6'h36, 10);
    check(mode, 2'h0);
    u_host_bus_model.drive(6'h37, 0);
    wait_mode(2'h1);
    $display("t_supply done");
  endtask
  task t_abort;
    u_host_bus_model.drive(6'h27, 1);
    u_host_bus_model.drive(6'h37, 12);
    check(mode, 2'h1);
    $display("t_abort done");
  endtask
  task t_sleep_wake;
    u_host_bus_model.drive(6'h3f, 4);
    u_host_bus_model.drive(6'h2f, 0);
    wait_mode(2'h3);
    u_host_bus_model.drive(6'h2f, 20);
    check(mode, 2'h3);
    check({rxd, flt_n}, 2'h3);
    // a pulse shorter than the filter must not wake
    u_host_bus_model.drive(6'h27, 3);
    u_host_bus_model.drive(6'h2f, 1);
    u_host_bus_model.drive(6'h27, 6);
    check(mode, 2'h3);
    u_host_bus_model.drive(6'h2f, 0);
    wait_mode(2'h0);
    check({1'b0, wpend}, 2'h1);
    @(posedge clk);
    #1;
    check({rxd, flt_n}, 2'h0);
    // report stands while the stale sleep pins are left unchanged
    u_host_bus_model.drive(6'h2f, 8);
    check(mode, 2'h0);
    check({rxd, flt_n}, 2'h0);
    // battery loss withdraws the report
    u_host_bus_model.drive(6'h2b, 6);
    check({1'b0, wpend}, 2'h0);
    check({rxd, flt_n}, 2'h3);
    check(mode, 2'h0);
    $display("t_sleep_wake done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #5;
    rst_n = 1'b1;
    t_supply();
    t_abort();
    t_sleep_wake();
    report_and_stop();
  end
endmodule // mode_ctrl_tb
